// *** common/tag_pkg.sv ***
// Shared constants and types for the memory tag transport
package tag_pkg;
  // Tag geometry
  localparam int TAG_BITS = 4;
  localparam int GRANULE_BYTES = 16;
  localparam int GRANULE_DATA_BITS = 128;
  localparam int MIN_TAG_DATA_WIDTH = 32;
  // Support levels
  typedef enum logic [1:0] {
    SUPPORT_NONE = 2'h0,
    SUPPORT_BASIC = 2'h1,
    SUPPORT_FULL = 2'h2
  } support_t;
  // Read tag operations
  typedef enum logic [1:0] {
    RD_TAG_NONE = 2'h0,
    RD_TAG_TRANSFER = 2'h1,
    RD_TAG_RESERVED = 2'h2,
    RD_TAG_FETCH = 2'h3
  } rd_tag_op_t;
  // Write tag operations
  typedef enum logic [1:0] {
    WR_TAG_NONE = 2'h0,
    WR_TAG_TRANSFER = 2'h1,
    WR_TAG_UPDATE = 2'h2,
    WR_TAG_MATCH = 2'h3
  } wr_tag_op_t;
  // Write match results
  typedef enum logic [1:0] {
    MATCH_NOT_MATCH = 2'h0,
    MATCH_SEPARATE = 2'h1,
    MATCH_FAIL = 2'h2,
    MATCH_PASS = 2'h3
  } match_t;
  // Number of tag slices for a data width
  function automatic int tag_slices(input int dataWidth);
    return (dataWidth + GRANULE_DATA_BITS - 1) / GRANULE_DATA_BITS;
  endfunction
  // Effective support level after the width limit
  function automatic support_t eff_support(input support_t lvl, input int dataWidth);
    return (dataWidth < MIN_TAG_DATA_WIDTH) ? SUPPORT_NONE : lvl;
  endfunction
endpackage

// *** common/tag_if.sv ***
// Interface carrying tagged read, write and write-response channels
`timescale 1ns/1ns
`default_nettype none
interface tag_if
  import tag_pkg::*;
#(
  parameter int DATA_WIDTH = 128,
  parameter int ADDR_WIDTH = 16,
  parameter int ID_WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst
);
  localparam int NT = tag_slices(DATA_WIDTH);
  // Read request
  logic arValid, arReady;
  logic [ADDR_WIDTH-1:0] arAddr;
  logic [ID_WIDTH-1:0] arId;
  logic [1:0] arTagOp;
  // Read data
  logic rValid, rReady;
  logic [ID_WIDTH-1:0] rId;
  logic [DATA_WIDTH-1:0] rData;
  logic [NT*TAG_BITS-1:0] rTag;
  // Write request and data, single beat
  logic awValid, awReady;
  logic [ADDR_WIDTH-1:0] awAddr;
  logic [ID_WIDTH-1:0] awId;
  logic [1:0] awTagOp;
  logic wValid, wReady;
  logic [DATA_WIDTH-1:0] wData;
  logic [NT*TAG_BITS-1:0] wTag;
  logic [NT-1:0] wTagUpdate;
  // Write response
  logic bValid, bReady;
  logic [ID_WIDTH-1:0] bId;
  logic [1:0] bTagMatch;
  logic bComp;

  modport master (
    input sys_clk, rst, arReady, rValid, rId, rData, rTag, awReady, wReady,
    bValid, bId, bTagMatch, bComp,
    output arValid, arAddr, arId, arTagOp, rReady, awValid, awAddr, awId, awTagOp,
    wValid, wData, wTag, wTagUpdate, bReady
  );
  modport slave (
    input sys_clk, rst, arValid, arAddr, arId, arTagOp, rReady, awValid, awAddr, awId,
    awTagOp, wValid, wData, wTag, wTagUpdate, bReady,
    output arReady, rValid, rId, rData, rTag, awReady, wReady, bValid, bId, bTagMatch,
    bComp
  );
endinterface
`default_nettype wire

// *** logic/tag_slave.sv ***
// Completer end: tagged memory with tag match on writes
//
// Overview of operation
// - One four-bit tag per 16-byte granule
// - Full support carries every tag signal
// - Basic support omits match result, completion optional
// - No support: no tags, undeclared means none
// - Data narrower than 32 bits forces none
// - Untagged slave ignores ops, static read tags
// - Full master needs full slave
// - Read op codes: none, transfer, reserved, fetch
// - Write op codes: none, transfer, update, match
// - Read tag slice per 128 data bits
// - Write tag slice per 128 data bits
// - Tags valid exactly with their data beats
// - Update mask bit per tag slice
// - Update stores masked tags only
// - Mask low outside transaction container
// - Mask low for non-update operations
// - Match result codes returned on response
// - Response completion flag marks observable write
// - Master checks tags returned on reads
// - Completer compares write tag, reports result
// - Tagged and untagged traffic may mix
// - Tagged write needs unique write ID
// - Tagged read needs unique read ID
`timescale 1ns/1ns
`default_nettype none
module tag_slave
  import tag_pkg::*;
#(
  parameter int DATA_WIDTH = 128,
  parameter int ADDR_WIDTH = 16,
  parameter int ID_WIDTH = 4,
  parameter int DEPTH = 16,
  parameter support_t SUPPORT = SUPPORT_NONE
) (
  // Bus side
  tag_if.slave bus,
  // Status
  output logic matchFailSeen
);
  // Derived geometry and the support level after the width limit
  localparam int NT = tag_slices(DATA_WIDTH);
  localparam int TW = NT * TAG_BITS;
  localparam support_t LVL = eff_support(SUPPORT, DATA_WIDTH);
  localparam int IW = $clog2(DEPTH);
  localparam int LSB = $clog2(DATA_WIDTH / 8);

  // Storage: data words and one tag per granule
  logic [DATA_WIDTH-1:0] memData_q [DEPTH];
  logic [TW-1:0] memTag_q [DEPTH];
  logic [DATA_WIDTH-1:0] memData_d [DEPTH];
  logic [TW-1:0] memTag_d [DEPTH];
  // Read return registers
  logic rValid_q, rValid_d;
  logic [ID_WIDTH-1:0] rId_q, rId_d;
  logic [DATA_WIDTH-1:0] rData_q, rData_d;
  logic [TW-1:0] rTag_q, rTag_d;
  // Write response registers
  logic bValid_q, bValid_d;
  logic [ID_WIDTH-1:0] bId_q, bId_d;
  logic [1:0] bMatch_q, bMatch_d;
  logic bComp_q, bComp_d;
  logic fail_q, fail_d;
  // Handshake decisions and word indices
  logic doRead, doWrite;
  logic [IW-1:0] rIdx, wIdx;

  function automatic logic [IW-1:0] word_index(input logic [ADDR_WIDTH-1:0] a);
    return IW'(a >> LSB);
  endfunction

  // Read ops that bring tags back on a tag-capable completer
  function automatic logic rd_wants_tags(input logic [1:0] op);
    return (LVL != SUPPORT_NONE) && (op == RD_TAG_TRANSFER || op == RD_TAG_FETCH);
  endfunction

  // Accept a read when the return slot is free; write when address and data meet and the response slot is free
  assign doRead = bus.arValid && (!rValid_q || bus.rReady);
  assign doWrite = bus.awValid && bus.wValid && (!bValid_q || bus.bReady);
  assign rIdx = word_index(bus.arAddr);
  assign wIdx = word_index(bus.awAddr);
  assign bus.arReady = doRead;
  assign bus.awReady = doWrite;
  assign bus.wReady = doWrite;
  assign bus.rValid = rValid_q;
  assign bus.rId = rId_q;
  assign bus.rData = rData_q;
  assign bus.rTag = rTag_q;
  assign bus.bValid = bValid_q;
  assign bus.bId = bId_q;
  assign bus.bTagMatch = bMatch_q;
  assign bus.bComp = bComp_q;
  assign matchFailSeen = fail_q;

  // Read return: data of the word, tags only when asked for and supported
  always_comb begin
    // Master is always ready, so a return stands one cycle
    rValid_d = rValid_q && !bus.rReady;
    rId_d = rId_q;
    rData_d = rData_q;
    rTag_d = rTag_q;
    if (doRead) begin
      rValid_d = 1'b1;
      rId_d = bus.arId;
      rData_d = memData_q[rIdx];
      // Untagged reads and untagged completers give a constant zero tag
      rTag_d = '0;
      if (rd_wants_tags(bus.arTagOp)) begin
        rTag_d = memTag_q[rIdx];
      end
    end
  end

  // Write path: tag match decided first, then data and tag storage
  always_comb begin
    logic isMatch;
    logic allPass;
    isMatch = 1'b0;
    allPass = 1'b1;
    memData_d = memData_q;
    memTag_d = memTag_q;
    bValid_d = bValid_q && !bus.bReady;
    bId_d = bId_q;
    bMatch_d = bMatch_q;
    bComp_d = bComp_q;
    fail_d = fail_q;
    if (doWrite) begin
      // Only a full completer answers a match; lower levels see a plain write
      isMatch = (LVL == SUPPORT_FULL) && (bus.awTagOp == WR_TAG_MATCH);
      allPass = (memTag_q[wIdx] == bus.wTag);
      bValid_d = 1'b1;
      bId_d = bus.awId;
      bMatch_d = MATCH_NOT_MATCH;
      bComp_d = (LVL == SUPPORT_FULL);
      if (isMatch) begin
        bMatch_d = allPass ? MATCH_PASS : MATCH_FAIL;
        // The sticky flag records any failed compare until reset
        fail_d = fail_q || !allPass;
      end
      // A failed match leaves the stored word untouched
      if (!isMatch || allPass) begin
        memData_d[wIdx] = bus.wData;
      end
      if (LVL != SUPPORT_NONE) begin
        unique case (wr_tag_op_t'(bus.awTagOp))
          // Plain writes and matches leave the stored tags alone
          WR_TAG_NONE, WR_TAG_MATCH: begin
          end
          WR_TAG_TRANSFER: begin
            memTag_d[wIdx] = bus.wTag;
          end
          WR_TAG_UPDATE: begin
            // Granules with a clear mask bit keep their old tag
            for (int n = 0; n < NT; n++) begin
              if (bus.wTagUpdate[n]) begin
                memTag_d[wIdx][n*TAG_BITS +: TAG_BITS] =
                  bus.wTag[n*TAG_BITS +: TAG_BITS];
              end
            end
          end
        endcase
      end
    end
  end

  // Register the read return channel
  always_ff @(posedge bus.sys_clk) begin
    if (bus.rst) begin
      rValid_q <= 1'b0;
      rId_q <= '0;
      rData_q <= '0;
      rTag_q <= '0;
    end else begin
      rValid_q <= rValid_d;
      rId_q <= rId_d;
      rData_q <= rData_d;
      rTag_q <= rTag_d;
    end
  end

  // Register storage, the write response and the sticky fail flag
  always_ff @(posedge bus.sys_clk) begin
    if (bus.rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        memData_q[i] <= '0;
        memTag_q[i] <= '0;
      end
      bValid_q <= 1'b0;
      bId_q <= '0;
      bMatch_q <= MATCH_NOT_MATCH;
      bComp_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      memData_q <= memData_d;
      memTag_q <= memTag_d;
      bValid_q <= bValid_d;
      bId_q <= bId_d;
      bMatch_q <= bMatch_d;
      bComp_q <= bComp_d;
      fail_q <= fail_d;
    end
  end
endmodule
`default_nettype wire

// *** logic/tag_master.sv ***
// Requester end: issues tagged reads and writes, checks returned tags
`timescale 1ns/1ns
`default_nettype none
module tag_master
  import tag_pkg::*;
#(
  parameter int DATA_WIDTH = 128,
  parameter int ADDR_WIDTH = 16,
  parameter int ID_WIDTH = 4
) (
  // Bus side
  tag_if.master bus,
  // Read command
  input wire logic rdReq,
  input wire logic [ADDR_WIDTH-1:0] rdAddr,
  input wire logic [ID_WIDTH-1:0] rdId,
  input wire logic [1:0] rdTagOp,
  input wire logic [tag_slices(DATA_WIDTH)*TAG_BITS-1:0] rdPhysTag,
  output logic rdBusy,
  // Read result
  output logic rdDone,
  output logic [DATA_WIDTH-1:0] rdData,
  output logic [tag_slices(DATA_WIDTH)*TAG_BITS-1:0] rdTag,
  output logic rdTagMismatch,
  // Write command
  input wire logic wrReq,
  input wire logic [ADDR_WIDTH-1:0] wrAddr,
  input wire logic [ID_WIDTH-1:0] wrId,
  input wire logic [1:0] wrTagOp,
  input wire logic [DATA_WIDTH-1:0] wrData,
  input wire logic [tag_slices(DATA_WIDTH)*TAG_BITS-1:0] wrTag,
  input wire logic [tag_slices(DATA_WIDTH)-1:0] wrTagMask,
  output logic wrBusy,
  // Write result
  output logic wrDone,
  output logic [1:0] wrMatch,
  output logic wrComp
);
  localparam int NT = tag_slices(DATA_WIDTH);
  localparam int TW = NT * TAG_BITS;

  // Read channel state: one outstanding read, so IDs are always unique
  logic arValid_q, arValid_d, rdBusy_q, rdBusy_d;
  logic [ADDR_WIDTH-1:0] arAddr_q, arAddr_d;
  logic [ID_WIDTH-1:0] arId_q, arId_d;
  logic [1:0] arOp_q, arOp_d;
  logic [TW-1:0] phys_q, phys_d;
  logic rdDone_q, rdDone_d, mis_q, mis_d;
  logic [DATA_WIDTH-1:0] rdData_q, rdData_d;
  logic [TW-1:0] rdTag_q, rdTag_d;
  // Write channel state: one outstanding write
  logic awValid_q, awValid_d, wValid_q, wValid_d, wrBusy_q, wrBusy_d;
  logic [ADDR_WIDTH-1:0] awAddr_q, awAddr_d;
  logic [ID_WIDTH-1:0] awId_q, awId_d;
  logic [1:0] awOp_q, awOp_d;
  logic [DATA_WIDTH-1:0] wData_q, wData_d;
  logic [TW-1:0] wTag_q, wTag_d;
  logic [NT-1:0] wUpd_q, wUpd_d;
  logic wrDone_q, wrDone_d, wrComp_q, wrComp_d;
  logic [1:0] wrMatch_q, wrMatch_d;

  assign bus.arValid = arValid_q;
  assign bus.arAddr = arAddr_q;
  assign bus.arId = arId_q;
  assign bus.arTagOp = arOp_q;
  assign bus.rReady = 1'b1;
  assign bus.awValid = awValid_q;
  assign bus.awAddr = awAddr_q;
  assign bus.awId = awId_q;
  assign bus.awTagOp = awOp_q;
  assign bus.wValid = wValid_q;
  assign bus.wData = wData_q;
  assign bus.wTag = wTag_q;
  assign bus.wTagUpdate = wUpd_q;
  assign bus.bReady = 1'b1;
  assign rdBusy = rdBusy_q;
  assign rdDone = rdDone_q;
  assign rdData = rdData_q;
  assign rdTag = rdTag_q;
  assign rdTagMismatch = mis_q;
  assign wrBusy = wrBusy_q;
  assign wrDone = wrDone_q;
  assign wrMatch = wrMatch_q;
  assign wrComp = wrComp_q;

  // Read issue and tag check
  always_comb begin
    arValid_d = arValid_q && !bus.arReady;
    rdBusy_d = rdBusy_q;
    arAddr_d = arAddr_q;
    arId_d = arId_q;
    arOp_d = arOp_q;
    phys_d = phys_q;
    rdDone_d = 1'b0;
    mis_d = mis_q;
    rdData_d = rdData_q;
    rdTag_d = rdTag_q;
    if (rdReq && !rdBusy_q) begin
      arValid_d = 1'b1;
      rdBusy_d = 1'b1;
      arAddr_d = rdAddr;
      arId_d = rdId;
      arOp_d = (rdTagOp == RD_TAG_RESERVED) ? RD_TAG_NONE : rdTagOp;
      phys_d = rdPhysTag;
    end
    if (bus.rValid && rdBusy_q && !arValid_q) begin
      rdBusy_d = 1'b0;
      rdDone_d = 1'b1;
      rdData_d = bus.rData;
      rdTag_d = bus.rTag;
      mis_d = (arOp_q != RD_TAG_NONE) && (bus.rTag != phys_q);
    end
  end

  // Write issue with mask hygiene
  always_comb begin
    awValid_d = awValid_q && !bus.awReady;
    wValid_d = wValid_q && !bus.wReady;
    wrBusy_d = wrBusy_q;
    awAddr_d = awAddr_q;
    awId_d = awId_q;
    awOp_d = awOp_q;
    wData_d = wData_q;
    wTag_d = wTag_q;
    wUpd_d = wUpd_q;
    wrDone_d = 1'b0;
    wrMatch_d = wrMatch_q;
    wrComp_d = wrComp_q;
    if (wrReq && !wrBusy_q) begin
      awValid_d = 1'b1;
      wValid_d = 1'b1;
      wrBusy_d = 1'b1;
      awAddr_d = wrAddr;
      awId_d = wrId;
      awOp_d = wrTagOp;
      wData_d = wrData;
      wTag_d = (wrTagOp == WR_TAG_NONE) ? '0 : wrTag;
      wUpd_d = (wrTagOp == WR_TAG_UPDATE) ? wrTagMask : '0;
    end
    if (bus.bValid && wrBusy_q && !awValid_q) begin
      wrBusy_d = 1'b0;
      wrDone_d = 1'b1;
      wrMatch_d = bus.bTagMatch;
      wrComp_d = bus.bComp;
    end
  end

  // Register all state
  always_ff @(posedge bus.sys_clk) begin
    if (bus.rst) begin
      arValid_q <= 1'b0;
      rdBusy_q <= 1'b0;
      arAddr_q <= '0;
      arId_q <= '0;
      arOp_q <= RD_TAG_NONE;
      phys_q <= '0;
      rdDone_q <= 1'b0;
      mis_q <= 1'b0;
      rdData_q <= '0;
      rdTag_q <= '0;
      awValid_q <= 1'b0;
      wValid_q <= 1'b0;
      wrBusy_q <= 1'b0;
      awAddr_q <= '0;
      awId_q <= '0;
      awOp_q <= WR_TAG_NONE;
      wData_q <= '0;
      wTag_q <= '0;
      wUpd_q <= '0;
      wrDone_q <= 1'b0;
      wrMatch_q <= MATCH_NOT_MATCH;
      wrComp_q <= 1'b0;
    end else begin
      arValid_q <= arValid_d;
      rdBusy_q <= rdBusy_d;
      arAddr_q <= arAddr_d;
      arId_q <= arId_d;
      arOp_q <= arOp_d;
      phys_q <= phys_d;
      rdDone_q <= rdDone_d;
      mis_q <= mis_d;
      rdData_q <= rdData_d;
      rdTag_q <= rdTag_d;
      awValid_q <= awValid_d;
      wValid_q <= wValid_d;
      wrBusy_q <= wrBusy_d;
      awAddr_q <= awAddr_d;
      awId_q <= awId_d;
      awOp_q <= awOp_d;
      wData_q <= wData_d;
      wTag_q <= wTag_d;
      wUpd_q <= wUpd_d;
      wrDone_q <= wrDone_d;
      wrMatch_q <= wrMatch_d;
      wrComp_q <= wrComp_d;
    end
  end
endmodule
`default_nettype wire

// *** test/tag_chk.sv ***
// Checker for the tag transport interface
`timescale 1ns/1ns
`default_nettype none
module tag_chk
  import tag_pkg::*;
#(
  parameter int DATA_WIDTH = 128,
  parameter int ID_WIDTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Read channels
  input wire logic arValid,
  input wire logic arReady,
  input wire logic [ID_WIDTH-1:0] arId,
  input wire logic [1:0] arTagOp,
  input wire logic rValid,
  input wire logic [ID_WIDTH-1:0] rId,
  input wire logic [tag_slices(DATA_WIDTH)*TAG_BITS-1:0] rTag,
  // Write channels
  input wire logic awValid,
  input wire logic awReady,
  input wire logic [1:0] awTagOp,
  input wire logic [ID_WIDTH-1:0] awId,
  input wire logic wValid,
  input wire logic wReady,
  input wire logic [tag_slices(DATA_WIDTH)*TAG_BITS-1:0] wTag,
  input wire logic [tag_slices(DATA_WIDTH)-1:0] wTagUpdate,
  input wire logic bValid,
  input wire logic [ID_WIDTH-1:0] bId,
  input wire logic [1:0] bTagMatch,
  input wire logic bComp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic rAcc;
  logic wAcc;
  // Requests taken by the slave
  assign rAcc = arValid && arReady;
  assign wAcc = awValid && wValid && awReady && wReady;
  property p_rdAnswer;
    rAcc |=> rValid && rId == $past(arId) ##1 !rValid;
  endproperty
  a_rdAnswer: assert property (p_rdAnswer)
    else $error("Read answer late or with wrong ID");
  property p_rdNone;
    rAcc && arTagOp == RD_TAG_NONE |=> rTag == '0;
  endproperty
  a_rdNone: assert property (p_rdNone)
    else $error("Read tag not zero for untagged read");
  property p_rsv;
    arValid |-> arTagOp != RD_TAG_RESERVED;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("Reserved read tag code on the bus");
  property p_wPair;
    awValid |-> wValid;
  endproperty
  a_wPair: assert property (p_wPair)
    else $error("Write request without its data beat");
  property p_wrAnswer;
    wAcc |=> bValid ##1 !bValid;
  endproperty
  a_wrAnswer: assert property (p_wrAnswer)
    else $error("Write response late or too long");
  property p_wrId;
    wAcc |=> bId == $past(awId);
  endproperty
  a_wrId: assert property (p_wrId)
    else $error("Write response with wrong ID");
  property p_mask;
    wValid && awTagOp != WR_TAG_UPDATE |-> wTagUpdate == '0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("Update mask set outside an update");
  property p_tagNone;
    wValid && awTagOp == WR_TAG_NONE |-> wTag == '0;
  endproperty
  a_tagNone: assert property (p_tagNone)
    else $error("Write tag not zero for untagged write");
  property p_comp;
    bValid |-> bComp;
  endproperty
  a_comp: assert property (p_comp)
    else $error("Write response without observable flag");
  property p_noMatch;
    wAcc && awTagOp != WR_TAG_MATCH |=> bTagMatch == MATCH_NOT_MATCH;
  endproperty
  a_noMatch: assert property (p_noMatch)
    else $error("Match result on a non-match write");
  property p_matchRes;
    wAcc && awTagOp == WR_TAG_MATCH |=> bTagMatch inside {MATCH_FAIL, MATCH_PASS};
  endproperty
  a_matchRes: assert property (p_matchRes)
    else $error("Match write without pass or fail");
  // Main scenarios
  c_pass: cover property (bValid && bTagMatch == MATCH_PASS);
  c_fail: cover property (bValid && bTagMatch == MATCH_FAIL);
  c_update: cover property (wAcc && awTagOp == WR_TAG_UPDATE);
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Bench joining a tag master and a full-support tag slave
`timescale 1ns/1ns
`default_nettype none
module testbench
  import tag_pkg::*;
;
  localparam int DW = 256;
  localparam int TW = 8;
  localparam logic [DW-1:0] D1 = {8{32'h1234ABCD}};
  localparam logic [DW-1:0] D2 = {8{32'hCAFE0001}};
  localparam logic [DW-1:0] D3 = {8{32'h0F0F5A5A}};
  logic sys_clk, rst, rdReq, wrReq, rdBusy, wrBusy, rdDone, wrDone;
  logic rdTagMismatch, wrComp, matchFailSeen;
  logic [15:0] rdAddr, wrAddr;
  logic [3:0] rdId, wrId;
  logic [1:0] rdTagOp, wrTagOp, wrMatch, wrTagMask;
  logic [TW-1:0] rdPhysTag, rdTag, wrTag;
  logic [DW-1:0] rdData, wrData;
  int error_cnt = 0;
  int checked = 0;
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  tag_if #(.DATA_WIDTH(DW)) i_tag_if (.sys_clk(sys_clk), .rst(rst));
  tag_master #(.DATA_WIDTH(DW)) i_tag_master (
    .bus(i_tag_if), .rdReq(rdReq), .rdAddr(rdAddr), .rdId(rdId), .rdTagOp(rdTagOp),
    .rdPhysTag(rdPhysTag), .rdBusy(rdBusy), .rdDone(rdDone), .rdData(rdData),
    .rdTag(rdTag), .rdTagMismatch(rdTagMismatch), .wrReq(wrReq), .wrAddr(wrAddr),
    .wrId(wrId), .wrTagOp(wrTagOp), .wrData(wrData), .wrTag(wrTag),
    .wrTagMask(wrTagMask), .wrBusy(wrBusy), .wrDone(wrDone), .wrMatch(wrMatch),
    .wrComp(wrComp)
  );
  tag_slave #(.DATA_WIDTH(DW), .SUPPORT(SUPPORT_FULL)) i_tag_slave (
    .bus(i_tag_if), .matchFailSeen(matchFailSeen)
  );
  tag_chk #(.DATA_WIDTH(DW), .ID_WIDTH(4)) i_tag_chk (
    .sys_clk(sys_clk), .rst(rst), .arValid(i_tag_if.arValid),
    .arReady(i_tag_if.arReady), .arId(i_tag_if.arId), .arTagOp(i_tag_if.arTagOp),
    .rValid(i_tag_if.rValid), .rId(i_tag_if.rId), .rTag(i_tag_if.rTag),
    .awValid(i_tag_if.awValid), .awReady(i_tag_if.awReady),
    .awTagOp(i_tag_if.awTagOp), .wValid(i_tag_if.wValid), .wReady(i_tag_if.wReady),
    .wTag(i_tag_if.wTag), .wTagUpdate(i_tag_if.wTagUpdate),
    .bValid(i_tag_if.bValid), .bTagMatch(i_tag_if.bTagMatch), .bComp(i_tag_if.bComp),
    .awId(i_tag_if.awId), .bId(i_tag_if.bId)
  );
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Bounded wait for a completion pulse
  task automatic waitDone(input bit isWr);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #2;
      n++;
    end while (((isWr ? wrDone : rdDone) !== 1'b1) && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, 1'b0, 1'b1);
      tally_and_finish();
    end
  endtask
  // One write through the master
  task automatic wr(input logic [15:0] a, input logic [1:0] op, input logic [DW-1:0] d,
      input logic [TW-1:0] t, input logic [1:0] m);
    @(posedge sys_clk);
    #2;
    wrAddr = a;
    wrId = a[8:5];
    wrTagOp = op;
    wrData = d;
    wrTag = t;
    wrTagMask = m;
    wrReq = 1'b1;
    @(posedge sys_clk);
    #2;
    wrReq = 1'b0;
    chk(DW'(wrBusy), DW'(1'b1));
    waitDone(1'b1);
    chk(DW'(wrBusy), DW'(1'b0));
  endtask
  // One read through the master
  task automatic rd(input logic [15:0] a, input logic [1:0] op, input logic [TW-1:0] p);
    @(posedge sys_clk);
    #2;
    rdAddr = a;
    rdId = a[8:5];
    rdTagOp = op;
    rdPhysTag = p;
    rdReq = 1'b1;
    @(posedge sys_clk);
    #2;
    rdReq = 1'b0;
    chk(DW'(rdBusy), DW'(1'b1));
    waitDone(1'b0);
    chk(DW'(rdBusy), DW'(1'b0));
  endtask
  // Watchdog
  initial begin
    #20000;
    error_cnt++;
    $display("Error at %0t: got %0h expected %0h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {rst, rdReq, wrReq, rdAddr, wrAddr, rdId, wrId} = '0;
    {rdTagOp, wrTagOp, wrTagMask, rdPhysTag, wrTag, wrData} = '0;
    rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    wr(16'h0020, WR_TAG_TRANSFER, D1, 8'h5A, 2'h3);
    chk(DW'(wrMatch), DW'(MATCH_NOT_MATCH));
    chk(DW'(wrComp), DW'(1'b1));
    rd(16'h0020, RD_TAG_TRANSFER, 8'h5A);
    chk(rdData, D1);
    chk(DW'(rdTag), DW'(8'h5A));
    chk(DW'(rdTagMismatch), DW'(1'b0));
    rd(16'h0020, RD_TAG_TRANSFER, 8'h5B);
    chk(DW'(rdTagMismatch), DW'(1'b1));
    // Only the low slice is selected by the mask
    wr(16'h0020, WR_TAG_UPDATE, D1, 8'h3C, 2'h1);
    rd(16'h0020, RD_TAG_FETCH, 8'h5C);
    chk(DW'(rdTag), DW'(8'h5C));
    chk(DW'(rdTagMismatch), DW'(1'b0));
    // Untagged traffic beside tagged traffic
    wr(16'h0040, WR_TAG_NONE, D3, 8'hFF, 2'h3);
    chk(DW'(wrMatch), DW'(MATCH_NOT_MATCH));
    rd(16'h0040, RD_TAG_NONE, 8'h77);
    chk(rdData, D3);
    chk(DW'(rdTag), DW'(8'h00));
    chk(DW'(rdTagMismatch), DW'(1'b0));
    // Match pass stores the data
    wr(16'h0020, WR_TAG_MATCH, D2, 8'h5C, 2'h0);
    chk(DW'(wrMatch), DW'(MATCH_PASS));
    chk(DW'(matchFailSeen), DW'(1'b0));
    rd(16'h0020, RD_TAG_TRANSFER, 8'h5C);
    chk(rdData, D2);
    // Match fail keeps the old data
    wr(16'h0020, WR_TAG_MATCH, D3, 8'hA5, 2'h0);
    chk(DW'(wrMatch), DW'(MATCH_FAIL));
    chk(DW'(wrComp), DW'(1'b1));
    chk(DW'(matchFailSeen), DW'(1'b1));
    rd(16'h0020, RD_TAG_TRANSFER, 8'h5C);
    chk(rdData, D2);
    chk(DW'(rdTag), DW'(8'h5C));
    // Reserved read code goes out as untagged
    rd(16'h0020, RD_TAG_RESERVED, 8'h5C);
    chk(DW'(rdTag), DW'(8'h00));
    chk(DW'(rdTagMismatch), DW'(1'b0));
    tally_and_finish();
  end
endmodule
`default_nettype wire
